// File: rtl/utpft_pkg.sv
package utpft_pkg;
   localparam int          PARAM_W     = 16;
   localparam int          IR_W        = 8;
   localparam int          CNT_W       = 8;
   localparam logic [IR_W-1:0]    TUNE_INSTR  = 8'h10;
   localparam logic [PARAM_W-1:0] PARAM_RESET = 16'h0000;
   localparam logic [CNT_W-1:0]   CNT_FULL    = 8'h10;
   localparam logic [CNT_W-1:0]   CNT_MAX     = 8'hff;
   localparam int          CLK_PERIOD_NS  = 20;
   localparam int          LINK_PERIOD_NS = 160;
   localparam int          LINK_HALF_CYC  = LINK_PERIOD_NS / (2 * CLK_PERIOD_NS);

   typedef enum logic [2:0] {
      UTPFT_IDLE  = 3'b001,
      UTPFT_SHIFT = 3'b010,
      UTPFT_HOLD  = 3'b100
   } utpft_state_t;
endpackage

// File: rtl/utpft_tile_if.sv
`timescale 1ns/10ps
interface utpft_tile_if;
   import utpft_pkg::*;
   logic               serial_in;
   logic               dr_shift;
   logic [IR_W-1:0]    instr;
   logic               clk_rise;
   logic               update_rise;

   modport sync (output serial_in, output dr_shift, output instr, output clk_rise, output update_rise);
   modport core (input serial_in, input dr_shift, input instr, input clk_rise, input update_rise);
endinterface

// File: rtl/utpft_tile_sync.sv
`timescale 1ns/10ps
module utpft_tile_sync
   import utpft_pkg::*;
(
   input  wire logic            mclk,
   input  wire logic            rst_n,
   input  wire logic            user_serial_in,
   input  wire logic            user_dr_shift_state,
   input  wire logic            user_dr_clock,
   input  wire logic            user_dr_update_strobe,
   input  wire logic [IR_W-1:0] user_ir,
   utpft_tile_if.sync           tile
);
   localparam int SW = IR_W + 4;

   logic [SW-1:0] meta;
   logic [SW-1:0] stable;
   logic          clk_last;
   logic          upd_last;
   logic [SW-1:0] next_meta;
   logic [SW-1:0] next_stable;
   logic          next_clk_last;
   logic          next_upd_last;

   ////////////////////////////////////////////////////////////////////////
   // Two stages per pin; edges are found on the second stage only
   always_comb begin
      next_meta     = {user_ir, user_serial_in, user_dr_shift_state, user_dr_clock, user_dr_update_strobe};
      next_stable   = meta;
      next_clk_last = stable[1];
      next_upd_last = stable[0];
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         meta     <= '0;
         stable   <= '0;
         clk_last <= 1'b0;
         upd_last <= 1'b0;
      end else begin
         meta     <= next_meta;
         stable   <= next_stable;
         clk_last <= next_clk_last;
         upd_last <= next_upd_last;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Data and clock share the same delay, so data stays aligned to its edge
   assign tile.instr       = stable[SW-1:4];
   assign tile.serial_in   = stable[3];
   assign tile.dr_shift    = stable[2];
   assign tile.clk_rise    = stable[1] & ~clk_last;
   assign tile.update_rise = stable[0] & ~upd_last;
endmodule

// File: rtl/utpft_core.sv
`timescale 1ns/10ps
module utpft_core
   import utpft_pkg::*;
(
   input  wire logic               mclk,
   input  wire logic               rst_n,
   input  wire logic               user_serial_in,
   input  wire logic               user_dr_shift_state,
   input  wire logic               user_dr_clock,
   input  wire logic               user_dr_update_strobe,
   input  wire logic [IR_W-1:0]    user_ir,
   output logic [PARAM_W-1:0]      param_value,
   output logic                    param_loaded,
   output logic                    shift_active,
   output logic                    length_mismatch,
   output logic                    user_serial_out
);
   utpft_tile_if tile ();

   utpft_tile_sync u_sync (
      .mclk                  (mclk),
      .rst_n                 (rst_n),
      .user_serial_in        (user_serial_in),
      .user_dr_shift_state   (user_dr_shift_state),
      .user_dr_clock         (user_dr_clock),
      .user_dr_update_strobe (user_dr_update_strobe),
      .user_ir               (user_ir),
      .tile                  (tile)
   );

   ////////////////////////////////////////////////////////////////////////
   // Instruction decode, shared by shift and update qualification
   function automatic logic tune_selected(input logic [IR_W-1:0] ir);
      return ir == TUNE_INSTR;
   endfunction

   function automatic logic [CNT_W-1:0] count_up(input logic [CNT_W-1:0] c);
      return (c == CNT_MAX) ? c : CNT_W'(c + 8'h01);
   endfunction

   // New bit enters at the top; the oldest bit leaves at bit 0
   function automatic logic [PARAM_W-1:0] shift_in(input logic [PARAM_W-1:0] r, input logic b);
      return {b, r[PARAM_W-1:1]};
   endfunction

   utpft_state_t         state;
   logic [PARAM_W-1:0]   temp;
   logic [CNT_W-1:0]     bit_cnt;
   utpft_state_t         next_state;
   logic [PARAM_W-1:0]   next_temp;
   logic [CNT_W-1:0]     next_bit_cnt;
   logic [PARAM_W-1:0]   next_param_value;
   logic                 next_param_loaded;
   logic                 next_shift_active;
   logic                 next_length_mismatch;
   logic                 next_user_serial_out;
   logic                 sel;
   logic                 do_shift;
   logic                 do_update;

   assign sel       = tune_selected(tile.instr);
   assign do_shift  = sel & tile.dr_shift & tile.clk_rise;
   assign do_update = sel & tile.update_rise;

   ////////////////////////////////////////////////////////////////////////
   // Sequencer: idle, shifting, one commit cycle
   always_comb begin
      next_state = state;
      unique case (state)
         UTPFT_IDLE: begin
            if (do_shift) begin
               next_state = UTPFT_SHIFT;
            end
         end
         UTPFT_SHIFT: begin
            if (do_update) begin
               next_state = UTPFT_HOLD;
            end else if (!sel) begin
               // Instruction changed mid-shift: drop the partial value
               next_state = UTPFT_IDLE;
            end
         end
         UTPFT_HOLD: begin
            next_state = UTPFT_IDLE;
         end
         default: begin
            next_state = UTPFT_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state <= UTPFT_IDLE;
      end else begin
         state <= next_state;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Temporary register and its readback bit
   always_comb begin
      next_temp = temp;
      unique case (state)
         UTPFT_IDLE: begin
            if (do_shift) begin
               next_temp = shift_in(temp, tile.serial_in);
            end
         end
         UTPFT_SHIFT: begin
            if (do_shift) begin
               next_temp = shift_in(temp, tile.serial_in);
            end
         end
         UTPFT_HOLD: begin
            // No bit is taken in the commit cycle, so the copy is exact
            next_temp = temp;
         end
         default: begin
            next_temp = temp;
         end
      endcase
      // Readback shows the oldest bit as soon as it moves
      next_user_serial_out = next_temp[0];
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         temp            <= PARAM_RESET;
         user_serial_out <= 1'b0;
      end else begin
         temp            <= next_temp;
         user_serial_out <= next_user_serial_out;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Bit counter saturates, so an over-long shift still reads as a mismatch
   always_comb begin
      next_bit_cnt = bit_cnt;
      unique case (state)
         UTPFT_IDLE: begin
            if (do_shift) begin
               next_bit_cnt = 8'h01;
            end
         end
         UTPFT_SHIFT: begin
            if (do_shift) begin
               next_bit_cnt = count_up(bit_cnt);
            end
         end
         UTPFT_HOLD: begin
            next_bit_cnt = '0;
         end
         default: begin
            next_bit_cnt = bit_cnt;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         bit_cnt <= '0;
      end else begin
         bit_cnt <= next_bit_cnt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Commit: the live value moves only here, never while shifting
   always_comb begin
      next_param_value     = param_value;
      next_param_loaded    = 1'b0;
      next_length_mismatch = length_mismatch;
      unique case (state)
         UTPFT_HOLD: begin
            next_param_value     = temp;
            next_param_loaded    = 1'b1;
            next_length_mismatch = (bit_cnt != CNT_FULL);
         end
         UTPFT_IDLE: begin
            next_param_value = param_value;
         end
         UTPFT_SHIFT: begin
            // Bits still arriving: the system keeps using the old value
            next_param_value = param_value;
         end
         default: begin
            next_param_value = param_value;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         param_value     <= PARAM_RESET;
         param_loaded    <= 1'b0;
         length_mismatch <= 1'b0;
      end else begin
         param_value     <= next_param_value;
         param_loaded    <= next_param_loaded;
         length_mismatch <= next_length_mismatch;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Busy flag; a fall with no load marks a dropped transfer
   always_comb begin
      next_shift_active = (state == UTPFT_SHIFT);
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         shift_active <= 1'b0;
      end else begin
         shift_active <= next_shift_active;
      end
   end
endmodule

// File: bench/utpft_core_assertions.sv
`timescale 1ns/10ps
module utpft_core_assertions
   import utpft_pkg::*;
(
   input wire logic               mclk,
   input wire logic               rst_n,
   input wire logic               user_serial_in,
   input wire logic               user_dr_shift_state,
   input wire logic               user_dr_clock,
   input wire logic               user_dr_update_strobe,
   input wire logic [IR_W-1:0]    user_ir,
   input wire logic [PARAM_W-1:0] param_value,
   input wire logic               param_loaded,
   input wire logic               shift_active,
   input wire logic               length_mismatch,
   input wire logic               user_serial_out
);
   default clocking dcb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);
   value_hold_a: assert property (!param_loaded |-> $stable(param_value)) else $error("param moved");
   load_pulse_a: assert property (param_loaded |=> !param_loaded) else $error("load too long");
   ir_gate_a: assert property (
      (user_ir != TUNE_INSTR)[*5] |=> $stable(user_serial_out) && !param_loaded)
      else $error("shift under wrong instruction");
   shift_gate_a: assert property ((!user_dr_shift_state)[*5] |=> $stable(user_serial_out))
      else $error("shift without enable");
   clk_step_a: assert property ($changed(user_serial_out) |-> $past(user_dr_clock, 3))
      else $error("step without link clock");
   commit_lat_a: assert property (
      $rose(user_dr_update_strobe) && shift_active && user_ir == TUNE_INSTR |-> ##[3:7] param_loaded)
      else $error("no commit");
   active_clr_a: assert property (param_loaded |-> !shift_active && $past(shift_active))
      else $error("commit without shift");
   flag_commit_a: assert property ($changed(length_mismatch) |-> param_loaded) else $error("flag moved");
   cover property (param_loaded && !length_mismatch);
   cover property (param_loaded && length_mismatch);
   cover property ($fell(shift_active) && !param_loaded);
endmodule

bind utpft_core utpft_core_assertions utpft_core_assertions_i (.*);

// File: bench/utpft_host.sv
`timescale 1ns/10ps
module utpft_host
   import utpft_pkg::*;
(
   input  wire logic       mclk,
   output logic            serial_in,
   output logic            dr_shift,
   output logic            dr_clock,
   output logic            dr_update,
   output logic [IR_W-1:0] ir
);
   initial begin
      {serial_in, dr_shift, dr_clock, dr_update, ir} = '0;
   end
   task automatic hw;
      repeat (LINK_HALF_CYC) @(posedge mclk);
   endtask
   task automatic xfer(input logic [IR_W-1:0] code, input logic [PARAM_W-1:0] d, input int n, input logic upd);
      ir <= code;
      hw;
      dr_shift <= 1'b1;
      for (int i = 0; i < n; i++) begin
         serial_in <= d[i];
         hw;
         dr_clock <= 1'b1;
         hw;
         dr_clock <= 1'b0;
      end
      dr_shift <= 1'b0;
      // Released line flips, never a stale copy
      serial_in <= ~serial_in;
      hw;
      dr_update <= upd;
      hw;
      dr_update <= 1'b0;
      hw;
      hw;
   endtask
endmodule

// File: bench/tb_top.sv
`timescale 1ns/10ps
module tb_top;
   import utpft_pkg::*;
   logic               mclk, rst_n, sin, shf, dck, upd, sout, ld, act, mis;
   logic [IR_W-1:0]    ir;
   logic [PARAM_W-1:0] pv, d, prev;
   int                 mismatches, num_checks, cyc, loads;
   utpft_host utpft_host_i (.mclk(mclk), .serial_in(sin), .dr_shift(shf), .dr_clock(dck),
      .dr_update(upd), .ir(ir));
   utpft_core utpft_core_i (.mclk(mclk), .rst_n(rst_n), .user_serial_in(sin), .user_dr_shift_state(shf),
      .user_dr_clock(dck), .user_dr_update_strobe(upd), .user_ir(ir), .param_value(pv),
      .param_loaded(ld), .shift_active(act), .length_mismatch(mis), .user_serial_out(sout));
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic chk(input logic [PARAM_W-1:0] got, input logic [PARAM_W-1:0] exp);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk_flag(input logic got, input logic exp);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR %0t: flag got %b exp %b", $time, got, exp);
      end
   endtask
   task automatic chk_count(input int got, input int exp);
      num_checks++;
      if (got != exp) begin
         mismatches++;
         $display("ERROR %0t: load count got %0d exp %0d", $time, got, exp);
      end
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   // Whole run needs about 1320 cycles
   always @(posedge mclk) begin
      cyc++;
      // An unknown pulse counts too, so it cannot hide
      if (ld !== 1'b0)
         loads++;
      if (cyc == 6000) begin
         mismatches++;
         results;
      end
   end
   initial begin
      rst_n = 1'b0;
      d = 16'h004f;
      repeat (2) @(posedge mclk);
      rst_n <= 1'b1;
      @(posedge mclk);
      chk(pv, PARAM_RESET);
      for (int i = 0; i < 5; i++) begin
         d = (i == 4) ? 16'hffff : lfsr(d);
         utpft_host_i.xfer(TUNE_INSTR, d, 16, 1'b1);
         chk(pv, d);
         chk_flag(mis, 1'b0);
         chk_flag(act, 1'b0);
         chk_flag(sout, d[0]);
         chk_count(loads, i + 1);
      end
      prev = lfsr(d);
      utpft_host_i.xfer(TUNE_INSTR, prev, 12, 1'b1);
      chk(pv, {prev[11:0], 4'hf});
      chk_flag(mis, 1'b1);
      chk_flag(sout, 1'b1);
      chk_count(loads, 6);
      prev = pv;
      d = lfsr(prev);
      utpft_host_i.xfer(TUNE_INSTR, d, 16, 1'b0);
      chk(pv, prev);
      chk_flag(act, 1'b1);
      chk_flag(sout, d[0]);
      chk_count(loads, 6);
      utpft_host_i.xfer(8'h11, ~d, 16, 1'b1);
      chk(pv, prev);
      chk_flag(act, 1'b0);
      chk_flag(sout, d[0]);
      chk_count(loads, 6);
      // Update with no bit shifted must not commit
      utpft_host_i.xfer(TUNE_INSTR, ~d, 0, 1'b1);
      chk(pv, prev);
      chk_flag(sout, d[0]);
      chk_count(loads, 6);
      // Full-length commit after a short one clears the mismatch flag
      d = lfsr(d);
      utpft_host_i.xfer(TUNE_INSTR, d, 16, 1'b1);
      chk(pv, d);
      chk_flag(mis, 1'b0);
      chk_count(loads, 7);
      results;
   end
endmodule
